// ### src/clres_defines.vh
// clres_defines.vh: offsets, field layout, reset values and scaling
// constants for the cell result and total register bank.
// assumes: included by bare name from the design files under src/.
`ifndef CLRES_DEFINES_VH
`define CLRES_DEFINES_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define CLRES_ADDR_W          8
`define CLRES_OFS_CODE_A      8'h53
`define CLRES_OFS_CODE_B      8'h54
`define CLRES_OFS_MODULE      8'h55
`define CLRES_OFS_CELL_SUM    8'h56

// ****************************************************************
// field layout and reset values
// ****************************************************************
`define CLRES_DATA_W          16
`define CLRES_CODE_W          14
`define CLRES_CODE_LSB        2
`define CLRES_CODE_MSB        15
`define CLRES_RESET_VAL       16'h0000
`define CLRES_UNMAPPED_VAL    16'h0000
`define CLRES_CLIP_LOW        16'h0000
`define CLRES_CLIP_HIGH       16'hFFFF

// ****************************************************************
// cell numbering of the results held here
// ****************************************************************
`define CLRES_IDX_W           4
`define CLRES_NUM_CELLS       14
`define CLRES_IDX_CODE_A      4'hD
`define CLRES_IDX_CODE_B      4'hE

// ****************************************************************
// scaling: cell step 5V/2^14, total step four cell steps (1.22mV)
// ****************************************************************
`define CLRES_CELL_FS_MV      5000
`define CLRES_MODULE_FS_MV    65000
`define CLRES_TOTAL_FS_MV     80000
`define CLRES_TOTAL_SHIFT     2
`define CLRES_ACC_W           20

`endif

// ### src/clres_sum_accum.v
// clres_sum_accum.v: scan accumulator for the cell sum result.
// assumes: scan start, add and done strobes come from logic on i_clk;
// codes arrive as 14-bit unipolar or two's complement bipolar values.
`timescale 1ns/1ps
`include "clres_defines.vh"

module clres_sum_accum #(
    parameter CODE_W = `CLRES_CODE_W,
    parameter ACC_W  = `CLRES_ACC_W
) (
    input  wire              i_clk,
    input  wire              i_rst,
    input  wire              i_scan_start,
    input  wire              i_add,
    input  wire [CODE_W-1:0] i_code,
    input  wire              i_bipolar,
    input  wire              i_scan_done,
    output reg  [15:0]       o_total
);

    // ************************************************************
    // code extension by polarity format
    // ************************************************************
    function [ACC_W-1:0] code_ext;
        input [CODE_W-1:0] c;
        input              bip;
        begin
            if (bip) begin
                code_ext = {{(ACC_W-CODE_W){c[CODE_W-1]}}, c};
            end else begin
                code_ext = {{(ACC_W-CODE_W){1'b0}}, c};
            end
        end
    endfunction

    reg  [ACC_W-1:0] acc_q;
    reg  [ACC_W-1:0] acc_d;
    reg  [ACC_W-1:0] base;
    wire [ACC_W-1:0] scaled;

    // ************************************************************
    // running sum of the current scan
    // ************************************************************
    always @* begin
        base  = i_scan_start ? {ACC_W{1'b0}} : acc_q;
        acc_d = base;
        if (i_add) begin
            acc_d = base + code_ext(i_code, i_bipolar);
        end
    end

    // arithmetic shift keeps sign for the clip test
    assign scaled = $signed(acc_d) >>> `CLRES_TOTAL_SHIFT;

    always @(posedge i_clk) begin
        if (i_rst) begin
            acc_q   <= {ACC_W{1'b0}};
            o_total <= `CLRES_RESET_VAL;
        end else begin
            acc_q <= acc_d;
            if (i_scan_done) begin
                if (scaled[ACC_W-1]) begin
                    o_total <= `CLRES_CLIP_LOW;
                end else if (|scaled[ACC_W-2:16]) begin
                    o_total <= `CLRES_CLIP_HIGH;
                end else begin
                    o_total <= scaled[15:0];
                end
            end
        end
    end

endmodule

// ### src/clres_regs.v
// clres_regs.v: read-only result registers for the upper two cells,
// the module voltage and the summed total of enabled cell results.
// Operation
// - cell results show their 14-bit code in bits 15:2
// - cell code full range corresponds to a 5V input
// - skipped disabled cell keeps stored data; readback picks filtered/raw
// - module result holds 14-bit code in bits 15:2, 65V full scale
// - skipped disabled module keeps stored data; readback picks source
// - total is 16-bit sum of cells enabled during the last scan
// - total is unsigned, 1.22mV step, range 0 to 80V
// - stale results of disabled measurements are not added to the total
// - unipolar and bipolar results are summed by their own format
// - current-sense channel results never enter the total
// - a negative total is clipped to 0x0000
// - all result registers are read-only and reset to 0x0000
// assumes: measurement engine strobes are on i_clk and one cycle long;
// the host port is a plain strobe bus, read data one cycle later.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "clres_defines.vh"

module clres_regs #(
    parameter ADDR_W    = `CLRES_ADDR_W,
    parameter CODE_W    = `CLRES_CODE_W,
    parameter IDX_W     = `CLRES_IDX_W,
    parameter NUM_CELLS = `CLRES_NUM_CELLS
) (
    input  wire                 i_clk,
    input  wire                 i_rst,
    // host register port
    input  wire [ADDR_W-1:0]    i_addr,
    input  wire [15:0]          i_wdata,
    input  wire                 i_wr,
    input  wire                 i_rd,
    output reg  [15:0]          o_rdata,
    output reg                  o_rvalid,
    // configuration levels
    input  wire [NUM_CELLS-1:0] i_cell_measure_enable,
    input  wire                 i_module_measure_enable,
    input  wire                 i_filtered_readback_select,
    // scan framing
    input  wire                 i_scan_start,
    input  wire                 i_scan_done,
    // per cell results
    input  wire                 i_cell_valid,
    input  wire [IDX_W-1:0]     i_cell_index,
    input  wire [CODE_W-1:0]    i_per_cell_code,
    input  wire [CODE_W-1:0]    i_per_cell_code_filt,
    input  wire                 i_cell_bipolar,
    input  wire                 i_current_sense_channel,
    // module voltage result
    input  wire                 i_module_valid,
    input  wire [CODE_W-1:0]    i_module_voltage_code,
    input  wire [CODE_W-1:0]    i_module_voltage_code_filt,
    output reg  [15:0]          o_cell_sum
);

    // ************************************************************
    // helpers
    // ************************************************************
    // place a 14-bit code at bits 15:2, low bits read zero
    function [15:0] left_justify;
        input [CODE_W-1:0] c;
        begin
            left_justify = {c, {`CLRES_CODE_LSB{1'b0}}};
        end
    endfunction

    // enable bit of a 1-based cell index, zero when out of range
    function cell_enabled;
        input [IDX_W-1:0]     idx;
        input [NUM_CELLS-1:0] en;
        integer k;
        begin
            cell_enabled = 1'b0;
            for (k = 0; k < NUM_CELLS; k = k + 1) begin
                if (idx == k[IDX_W-1:0] + 1'b1) begin
                    cell_enabled = en[k];
                end
            end
        end
    endfunction

    // ************************************************************
    // stored raw and filtered results
    // ************************************************************
    reg  [CODE_W-1:0] code_a_raw_q;
    reg  [CODE_W-1:0] code_a_filt_q;
    reg  [CODE_W-1:0] code_b_raw_q;
    reg  [CODE_W-1:0] code_b_filt_q;
    reg  [CODE_W-1:0] module_raw_q;
    reg  [CODE_W-1:0] module_filt_q;

    wire              cell_take;
    wire              cell_add;
    wire              module_take;
    wire [15:0]       total;

    // a disabled cell is skipped by the engine; its stale data stays
    assign cell_take = i_cell_valid &
                       cell_enabled(i_cell_index,
                                    i_cell_measure_enable);
    // only results taken in this scan, never current sense
    assign cell_add  = cell_take & ~i_current_sense_channel;
    assign module_take = i_module_valid & i_module_measure_enable;

    always @(posedge i_clk) begin
        if (i_rst) begin
            code_a_raw_q  <= {CODE_W{1'b0}};
            code_a_filt_q <= {CODE_W{1'b0}};
            code_b_raw_q  <= {CODE_W{1'b0}};
            code_b_filt_q <= {CODE_W{1'b0}};
            module_raw_q  <= {CODE_W{1'b0}};
            module_filt_q <= {CODE_W{1'b0}};
        end else begin
            // cell codes are 5V full scale values, module codes 65V full scale
            if (cell_take && i_cell_index == `CLRES_IDX_CODE_A) begin
                code_a_raw_q  <= i_per_cell_code;
                code_a_filt_q <= i_per_cell_code_filt;
            end
            if (cell_take && i_cell_index == `CLRES_IDX_CODE_B) begin
                code_b_raw_q  <= i_per_cell_code;
                code_b_filt_q <= i_per_cell_code_filt;
            end
            if (module_take) begin
                module_raw_q  <= i_module_voltage_code;
                module_filt_q <= i_module_voltage_code_filt;
            end
        end
    end

    // ************************************************************
    // total of enabled cell results
    // ************************************************************
    clres_sum_accum #(
        .CODE_W (CODE_W),
        .ACC_W  (`CLRES_ACC_W)
    ) u_accum (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_scan_start (i_scan_start),
        .i_add        (cell_add),
        .i_code       (i_per_cell_code),
        .i_bipolar    (i_cell_bipolar),
        .i_scan_done  (i_scan_done),
        .o_total      (total)
    );

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_cell_sum <= `CLRES_RESET_VAL;
        end else begin
            o_cell_sum <= total;
        end
    end

    // ************************************************************
    // host read path
    // ************************************************************
    reg [15:0] rdata_d;
    reg [CODE_W-1:0] sel_a;
    reg [CODE_W-1:0] sel_b;
    reg [CODE_W-1:0] sel_m;

    always @* begin
        sel_a = i_filtered_readback_select ? code_a_filt_q
                                           : code_a_raw_q;
        sel_b = i_filtered_readback_select ? code_b_filt_q
                                           : code_b_raw_q;
        sel_m = i_filtered_readback_select ? module_filt_q
                                           : module_raw_q;
        case (i_addr)
            `CLRES_OFS_CODE_A: begin
                rdata_d = left_justify(sel_a);
            end
            `CLRES_OFS_CODE_B: begin
                rdata_d = left_justify(sel_b);
            end
            `CLRES_OFS_MODULE: begin
                rdata_d = left_justify(sel_m);
            end
            `CLRES_OFS_CELL_SUM: begin
                rdata_d = total;
            end
            default: begin
                rdata_d = `CLRES_UNMAPPED_VAL;
            end
        endcase
    end

    // i_wdata is ignored and a write only blocks o_rvalid of a same-cycle read: every register here is read-only
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata  <= `CLRES_RESET_VAL;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd & ~i_wr;
            if (i_rd) begin
                o_rdata <= rdata_d;
            end else begin
                o_rdata <= `CLRES_RESET_VAL;
            end
        end
    end

endmodule

// ### test/clres_regs_asserts.sv
// clres_regs_asserts.sv: port checks for the result register bank.
// assumes: bound into clres_regs; one clock, sync reset active high.
`timescale 1ns/1ps
module clres_regs_asserts #(
    parameter ADDR_W = 8
) (
    input wire              i_clk,
    input wire              i_rst,
    input wire [ADDR_W-1:0] i_addr,
    input wire              i_wr,
    input wire              i_rd,
    input wire [15:0]       o_rdata,
    input wire              o_rvalid,
    input wire              i_scan_start,
    input wire              i_scan_done,
    input wire              i_cell_valid,
    input wire [15:0]       o_cell_sum
);
    // ****************************************
    // read port and total checks
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire code_rd = i_rd && i_addr >= 8'h53 && i_addr <= 8'h55;
    wire bad_rd  = i_rd && (i_addr < 8'h53 || i_addr > 8'h56);

    a_reset_clear: assert property (disable iff (1'b0)
        i_rst |=> o_rdata == 16'h0000 && !o_rvalid && o_cell_sum == 16'h0000)
        else $error("outputs not clear after reset");
    a_read_answer: assert property (i_rd |=> o_rvalid)
        else $error("read not answered");
    a_idle_quiet: assert property (!i_rd |=> !o_rvalid && o_rdata == 0)
        else $error("read port active without read");
    a_code_justify: assert property (code_rd |=> o_rdata[1:0] == 2'b00)
        else $error("code not left justified");
    a_unmapped_zero: assert property (bad_rd |=> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_wr_silent: assert property (i_wr && !i_rd |=> !o_rvalid)
        else $error("write produced read data");
    a_sum_matches: assert property (i_rd && i_addr == 8'h56
        |=> o_rdata == o_cell_sum) else $error("total view mismatch");
    a_sum_on_done: assert property ($changed(o_cell_sum)
        |-> $past(i_scan_done, 2)) else $error("total moved off scan end");
    a_empty_scan: assert property ((i_scan_start && !i_cell_valid)
        ##1 (i_scan_done && !i_cell_valid) |-> ##2 o_cell_sum == 16'h0000)
        else $error("empty scan total not zero");

    c_sum_nonzero: cover property (i_scan_done ##2 o_cell_sum != 0);
    c_code_read: cover property (code_rd ##1 o_rdata != 0);
    c_wr_then_rd: cover property (i_wr ##1 i_rd);
endmodule

bind clres_regs clres_regs_asserts #(.ADDR_W(ADDR_W)) i_chk (.i_clk,
    .i_rst, .i_addr, .i_wr, .i_rd, .o_rdata, .o_rvalid, .i_scan_start,
    .i_scan_done, .i_cell_valid, .o_cell_sum);

// ### test/clres_regs_tb_top.sv
// clres_regs_tb_top.sv: self-checking bench with a scan and total model.
// assumes: design and checker compiled first; 25 MHz clock.
`timescale 1ns/1ps
module clres_regs_tb_top;
    logic        i_clk, i_rst, i_wr, i_rd, i_module_measure_enable, fs;
    logic        i_filtered_readback_select, i_scan_start, i_scan_done;
    logic        i_cell_valid, i_cell_bipolar, i_current_sense_channel;
    logic        i_module_valid, o_rvalid;
    logic [7:0]  i_addr;
    logic [15:0] i_wdata, o_rdata, o_cell_sum, tot;
    logic [13:0] i_cell_measure_enable, i_per_cell_code, mraw, mflt;
    logic [13:0] i_per_cell_code_filt, i_module_voltage_code;
    logic [13:0] i_module_voltage_code_filt, raw[16], flt[16];
    logic [3:0]  i_cell_index;
    logic [31:0] seed = 32'h85959481;
    int          num_errors, compares, acc;

    clres_regs i_clres_regs (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
        .i_rd, .o_rdata, .o_rvalid, .i_cell_measure_enable,
        .i_module_measure_enable, .i_filtered_readback_select,
        .i_scan_start, .i_scan_done, .i_cell_valid, .i_cell_index,
        .i_per_cell_code, .i_per_cell_code_filt, .i_cell_bipolar,
        .i_current_sense_channel, .i_module_valid, .i_module_voltage_code,
        .i_module_voltage_code_filt, .o_cell_sum);

    // ****************************************
    // helpers
    // ****************************************
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input string n, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // strobes: start, done, cell, module, read, write
    task tick(input logic [5:0] s);
        @(posedge i_clk);
        {i_scan_start, i_scan_done, i_cell_valid, i_module_valid, i_rd,
            i_wr} <= s;
    endtask
    task rdchk(input logic [7:0] a, input logic [15:0] e);
        tick(6'h02);
        i_addr <= a;
        tick(6'h00);
        #1;
        chk("rvalid", 16'h0001, {15'h0000, o_rvalid});
        chk("rdata", e, o_rdata);
    endtask
    task readall();
        for (int i = 0; i < 4; i++) begin
            tick(6'h01);
            i_addr <= 8'(8'h53 + i);
            i_wdata <= 16'(rnd());
        end
        fs = 1'(rnd());
        i_filtered_readback_select <= fs;
        rdchk(8'h53, {fs ? flt[13] : raw[13], 2'b00});
        rdchk(8'h54, {fs ? flt[14] : raw[14], 2'b00});
        rdchk(8'h55, {fs ? mflt : mraw, 2'b00});
        rdchk(8'h56, tot);
        rdchk(8'h57, 16'h0000);
        chk("cell_sum", tot, o_cell_sum);
    endtask
    // model of one scan of n results, neg forces negative bipolar codes
    task scan(input int n, input logic neg);
        int v;
        logic [13:0] c;
        logic [3:0] x;
        logic b, s;
        acc = 0;
        tick(6'h20);
        i_cell_measure_enable <= 14'(rnd());
        i_module_measure_enable <= 1'(rnd());
        for (int i = 0; i < n; i++) begin
            c = 14'(rnd());
            x = 4'(rnd());
            b = neg | 1'(rnd());
            s = !neg & 1'(rnd());
            c[13] = c[13] | neg;
            tick(6'h08);
            {i_cell_index, i_per_cell_code, i_cell_bipolar} <= {x, c, b};
            i_per_cell_code_filt <= ~c;
            i_current_sense_channel <= s;
            if (x > 0 && x < 15 && i_cell_measure_enable[x - 1]) begin
                raw[x] = c;
                flt[x] = ~c;
                v = (b && c[13]) ? c - 16384 : c;
                acc += s ? 0 : v;
            end
        end
        if (n > 0) begin
            c = 14'(rnd());
            tick(6'h04);
            i_module_voltage_code <= c;
            i_module_voltage_code_filt <= ~c;
            mraw = i_module_measure_enable ? c : mraw;
            mflt = i_module_measure_enable ? ~c : mflt;
        end
        tick(6'h10);
        v = acc >>> 2;
        tot = v < 0 ? 16'h0000 : (v > 65535 ? 16'hFFFF : 16'(v));
        repeat (3) tick(6'h00);
    endtask
    task tally_and_finish();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ****************************************
    // clock, sequence and watchdog
    // ****************************************
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    initial begin
        {i_addr, i_wdata, i_wr, i_rd, i_scan_start, i_scan_done} = '0;
        {i_cell_valid, i_cell_index, i_per_cell_code, fs} = '0;
        {i_per_cell_code_filt, i_cell_bipolar, i_module_valid} = '0;
        {i_current_sense_channel, i_module_voltage_code} = '0;
        {i_module_voltage_code_filt, i_module_measure_enable} = '0;
        {i_cell_measure_enable, i_filtered_readback_select} = '0;
        {mraw, mflt, tot} = '0;
        foreach (raw[i]) {raw[i], flt[i]} = '0;
        i_rst = 1'b1;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        readall();
        $display("test reset_values done");
        repeat (30) begin
            scan(1 + rnd() % 14, 1'b0);
            readall();
        end
        $display("test random_scans done");
        repeat (3) begin
            scan(6, 1'b1);
            readall();
        end
        $display("test negative_clip done");
        scan(0, 1'b0);
        readall();
        $display("test empty_scan done");
        tally_and_finish();
    end
    initial begin
        #400000;
        num_errors++;
        tally_and_finish();
    end
endmodule
